// File: src/wake_timer_params.svh
`ifndef WAKE_TIMER_PARAMS_SVH
`define WAKE_TIMER_PARAMS_SVH

// register indices; the byte address on the bus is four times the index
`define PMC_INDEX 8'h87
`define WTC_INDEX 8'hce
`define STAT_INDEX 8'hd0

// wake timer control fields
`define WTC_RUN_BIT 7
`define WTC_FLAG_BIT 6
`define WTC_SEL_LSB 0
`define WTC_SEL_W 4
`define WTC_RESET 8'h00
`define WTC_SEL_MAX 4'h8

// power mode control fields
`define PMC_STOP_BIT 1
`define PMC_IDLE_BIT 0

// status fields
`define STAT_IDLE_BIT 0
`define STAT_STOP_BIT 1
`define STAT_OSC_BIT 2
`define STAT_RUN_BIT 3

// bus
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'h0

// timing: system and low-frequency rates in kHz, shortest period in ns
`define SYS_KHZ 17'd100000
`define LF_KHZ 17'd128
`define BASE_PERIOD_NS 64'd15625000
`define BASE_TICKS ((`BASE_PERIOD_NS * 64'd128) / 64'd1000000)

`endif

// File: src/wake_timer_pkg.sv
`include "wake_timer_params.svh"

package wake_timer_pkg;

   typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_STOP} pm_state_t;

   // events from the core and interrupt logic
   typedef struct packed {
      logic irq_ack_wake;
      logic ext_irq_group0;
      logic ext_irq_group2;
      logic ext_reset_in;
      logic any_irq_enabled;
      logic wdt_enable;
   } cpu_events_t;

   function automatic logic interval_valid(input logic [3:0] sel);
      interval_valid = (sel <= `WTC_SEL_MAX);
   endfunction

   // low-frequency cycles in one period of the selected interval
   function automatic logic [19:0] interval_ticks(input logic [3:0] sel,
                                                  input logic [19:0] base);
      interval_ticks = base << sel[3:0];
   endfunction

endpackage

// File: src/lf_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none
`include "wake_timer_params.svh"

module lf_tick_gen
   import wake_timer_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // oscillator
   input wire logic osc_on,
   output logic lf_tick
);

   logic [16:0] acc_reg;
   logic [16:0] acc_sum;

   // phase accumulator gives an exact 128 kHz average without a second clock
   assign acc_sum = acc_reg + `LF_KHZ;

   always_ff @(posedge ref_clk) begin
      if (!nrst || !osc_on) begin
         acc_reg <= 17'h0;
         lf_tick <= 1'b0;
      end else if (acc_sum >= `SYS_KHZ) begin
         acc_reg <= acc_sum - `SYS_KHZ;
         lf_tick <= 1'b1;
      end else begin
         acc_reg <= acc_sum;
         lf_tick <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// File: src/wake_interval_timer.sv
`timescale 1ns/1ns
`default_nettype none

module wake_interval_timer
   import wake_timer_pkg::*;
#(
   parameter int unsigned BASE_TICKS = 2000
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // control
   input wire logic run,
   input wire logic lf_tick,
   input wire logic [3:0] sel,
   // event
   output logic expire
);

   logic [19:0] count_reg;
   logic [19:0] last;

   assign last = interval_ticks(sel, BASE_TICKS[19:0]) - 20'h1;

   // reserved codes clear the count so no event is ever raised
   always_ff @(posedge ref_clk) begin
      if (!nrst || !run || !interval_valid(sel)) begin
         count_reg <= 20'h0;
         expire <= 1'b0;
      end else if (lf_tick && count_reg >= last) begin
         count_reg <= 20'h0;
         expire <= 1'b1;
      end else begin
         count_reg <= count_reg + {19'h0, lf_tick};
         expire <= 1'b0;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   period_count_a: assert property (expire |-> $past(count_reg) == $past(last))
      else $error("expire away from the selected period");
   reserved_quiet_a: assert property (!interval_valid(sel) |=> !expire)
      else $error("expire under a reserved interval code");

endmodule

`default_nettype wire

// File: src/wake_timer_power_modes.sv
// Function
// - interrupt acceptance clears the wake flag
// - software may clear the wake flag
// - interval codes 0..8 give 15.625ms..4s
// - stop bit halts high-frequency clock
// - stop left on group0, group2, timer, reset
// - oscillator and watchdog independent of stop
// - idle bit halts program execution
// - idle keeps clocks and processor state
// - any enabled interrupt ends idle
// - power mode register is write-only
// - run bit starts and stops timer
// - oscillator on for timer or watchdog
`timescale 1ns/1ns
`default_nettype none
`include "wake_timer_params.svh"

module wake_timer_power_modes
   import wake_timer_pkg::*;
#(
   parameter int unsigned BASE_TICKS = 32'(`BASE_TICKS)
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // core and interrupt logic
   input wire cpu_events_t cpu_ev,
   output logic wake_irq,
   output logic hf_clk_en,
   output logic cpu_hold,
   output logic lf_osc_en
);

   // bus phase state
   logic ph_valid_reg;
   logic ph_write_reg;
   logic ph_hit_reg;
   logic [7:0] ph_index_reg;
   logic addr_take;
   logic wr_wtc;
   logic wr_pmc;

   // wake timer control
   logic run_reg;
   logic [3:0] sel_reg;
   logic flag_reg;
   logic flag_next;
   logic lf_tick;
   logic expire;

   // power modes
   pm_state_t pm_reg;
   pm_state_t pm_next;
   logic stop_wake;

   function automatic logic addr_ok(input logic [31:0] a);
      addr_ok = (a[31:10] == 22'h0) && (a[1:0] == 2'h0);
   endfunction

   // ---------------- bus slave ----------------
   assign addr_take = hsel && htrans[1] && hready;

   // one wait state lets read data come straight from a flop
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ph_valid_reg <= 1'b0;
         ph_write_reg <= 1'b0;
         ph_hit_reg <= 1'b0;
         ph_index_reg <= 8'h0;
         hreadyout <= 1'b1;
      end else if (addr_take) begin
         ph_valid_reg <= 1'b1;
         ph_write_reg <= hwrite;
         ph_hit_reg <= addr_ok(haddr) && (hsize == `HSIZE_WORD);
         ph_index_reg <= haddr[9:2];
         hreadyout <= 1'b0;
      end else begin
         ph_valid_reg <= 1'b0;
         hreadyout <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         hresp <= `HRESP_OKAY;
      end else begin
         hresp <= `HRESP_OKAY;
      end
   end

   assign wr_wtc = ph_valid_reg && ph_write_reg && ph_hit_reg && ph_index_reg == `WTC_INDEX;
   assign wr_pmc = ph_valid_reg && ph_write_reg && ph_hit_reg && ph_index_reg == `PMC_INDEX;

   // power mode control has no read path: it reads as zero like any unmapped word
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         hrdata <= 32'h0;
      end else if (ph_valid_reg && !ph_write_reg && ph_hit_reg) begin
         unique case (ph_index_reg)
            `WTC_INDEX: begin
               hrdata <= {24'h0, run_reg, flag_reg, 2'h0, sel_reg};
            end
            `STAT_INDEX: begin
               hrdata <= {28'h0, run_reg && interval_valid(sel_reg), lf_osc_en,
                          pm_reg == PM_STOP, pm_reg == PM_IDLE};
            end
            default: begin
               hrdata <= 32'h0;
            end
         endcase
      end else begin
         hrdata <= 32'h0;
      end
   end

   // ---------------- wake timer ----------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         run_reg <= 1'(`WTC_RESET >> `WTC_RUN_BIT);
         sel_reg <= 4'h0;
      end else if (wr_wtc) begin
         run_reg <= hwdata[`WTC_RUN_BIT];
         sel_reg <= hwdata[`WTC_SEL_LSB +: `WTC_SEL_W];
      end
   end

   // a period that ends in the clearing cycle still leaves the flag set
   always_comb begin
      flag_next = flag_reg;
      if (expire) begin
         flag_next = 1'b1;
      end else if (cpu_ev.irq_ack_wake) begin
         flag_next = 1'b0;
      end else if (wr_wtc && !hwdata[`WTC_FLAG_BIT]) begin
         flag_next = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign wake_irq = flag_reg;

   // oscillator follows timer and watchdog only, never the power mode
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         lf_osc_en <= 1'b0;
      end else begin
         lf_osc_en <= run_reg || cpu_ev.wdt_enable;
      end
   end

   lf_tick_gen u_tick (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .osc_on(lf_osc_en),
      .lf_tick(lf_tick)
   );

   wake_interval_timer #(
      .BASE_TICKS(BASE_TICKS)
   ) u_interval (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .run(run_reg && lf_osc_en),
      .lf_tick(lf_tick),
      .sel(sel_reg),
      .expire(expire)
   );

   // ---------------- power modes ----------------
   assign stop_wake = cpu_ev.ext_irq_group0 || cpu_ev.ext_irq_group2 ||
                      flag_reg || cpu_ev.ext_reset_in;

   // stop wins when both bits are written together
   always_comb begin
      pm_next = pm_reg;
      unique case (pm_reg)
         PM_RUN: begin
            if (wr_pmc && hwdata[`PMC_STOP_BIT]) begin
               pm_next = PM_STOP;
            end else if (wr_pmc && hwdata[`PMC_IDLE_BIT]) begin
               pm_next = PM_IDLE;
            end
         end
         PM_IDLE: begin
            if (cpu_ev.any_irq_enabled) begin
               pm_next = PM_RUN;
            end
         end
         PM_STOP: begin
            if (stop_wake) begin
               pm_next = PM_RUN;
            end
         end
         default: begin
            pm_next = PM_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pm_reg <= PM_RUN;
      end else begin
         pm_reg <= pm_next;
      end
   end

   // the core just holds in idle, so its state survives untouched
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         hf_clk_en <= 1'b1;
         cpu_hold <= 1'b0;
      end else begin
         hf_clk_en <= pm_next != PM_STOP;
         cpu_hold <= pm_next != PM_RUN;
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   flag_ack_clear_a: assert property (
      cpu_ev.irq_ack_wake && !expire |=> !flag_reg)
      else $error("accepted wake interrupt left the flag set");

   flag_sw_clear_a: assert property (
      wr_wtc && !hwdata[`WTC_FLAG_BIT] && !expire |=> !flag_reg)
      else $error("software clear of the wake flag ignored");

   flag_set_wins_a: assert property (
      expire |=> flag_reg && wake_irq)
      else $error("period end did not set the wake flag");

   stop_entry_a: assert property (
      pm_reg == PM_RUN && wr_pmc && hwdata[`PMC_STOP_BIT]
      |=> pm_reg == PM_STOP && !hf_clk_en && cpu_hold)
      else $error("stop request did not halt the fast clock");

   stop_hold_a: assert property (
      pm_reg == PM_STOP && !stop_wake |=> pm_reg == PM_STOP && !hf_clk_en)
      else $error("stop left without a wake event");

   stop_exit_a: assert property (
      pm_reg == PM_STOP && stop_wake |=> pm_reg == PM_RUN && hf_clk_en && !cpu_hold)
      else $error("wake event did not end stop");

   idle_entry_a: assert property (
      pm_reg == PM_RUN && wr_pmc && !hwdata[`PMC_STOP_BIT] && hwdata[`PMC_IDLE_BIT]
      |=> pm_reg == PM_IDLE && cpu_hold && hf_clk_en)
      else $error("idle request did not halt execution");

   idle_keep_a: assert property (
      pm_reg == PM_IDLE && !cpu_ev.any_irq_enabled
      |=> pm_reg == PM_IDLE && hf_clk_en && cpu_hold)
      else $error("idle lost clocks or hold");

   idle_exit_a: assert property (
      pm_reg == PM_IDLE && cpu_ev.any_irq_enabled |=> !cpu_hold && pm_reg == PM_RUN)
      else $error("interrupt did not end idle");

   pmc_read_zero_a: assert property (
      addr_take && !hwrite && addr_ok(haddr) && haddr[9:2] == `PMC_INDEX
      |=> ##1 hrdata == 32'h0 && hreadyout)
      else $error("power mode register returned data");

   osc_stop_indep_a: assert property (
      pm_reg == PM_STOP && cpu_ev.wdt_enable |=> lf_osc_en)
      else $error("oscillator stopped with the fast clock");

   osc_demand_a: assert property (
      (run_reg || cpu_ev.wdt_enable) |=> lf_osc_en)
      else $error("oscillator off while needed");

   timer_stopped_a: assert property (
      !run_reg [*3] |-> !expire && !$rose(flag_reg))
      else $error("stopped timer raised an event");

   // one wait state per transfer, so ready simply mirrors the data phase flag
   bus_one_wait_a: assert property (
      addr_take |=> !hreadyout ##1 hreadyout)
      else $error("bus transfer not answered after one wait state");

   ready_phase_a: assert property (
      hreadyout == !ph_valid_reg)
      else $error("ready out of step with the data phase");

   timer_ctl_write_a: assert property (
      wr_wtc |=> run_reg == $past(hwdata[`WTC_RUN_BIT])
      && sel_reg == $past(hwdata[`WTC_SEL_LSB +: `WTC_SEL_W]))
      else $error("wake timer control write not applied");

   osc_release_a: assert property (
      !run_reg && !cpu_ev.wdt_enable |=> !lf_osc_en)
      else $error("oscillator left on with no user");

   stop_timer_osc_a: assert property (
      pm_reg == PM_STOP && run_reg |=> lf_osc_en)
      else $error("running wake timer lost its oscillator in stop");

   // a cleared flag must come from an acknowledge or a write, never by itself
   flag_hold_a: assert property (
      flag_reg && !cpu_ev.irq_ack_wake && !wr_wtc |=> flag_reg)
      else $error("wake flag dropped without a clear");

   // mode writes while halted are dropped; only a wake source ends idle
   idle_write_ignored_a: assert property (
      pm_reg == PM_IDLE && wr_pmc && !cpu_ev.any_irq_enabled |=> pm_reg == PM_IDLE)
      else $error("mode write changed the idle state");

   stop_timer_wake_c: cover property (
      pm_reg == PM_STOP && expire ##[1:3] pm_reg == PM_RUN);
   idle_irq_wake_c: cover property (
      pm_reg == PM_IDLE ##1 pm_reg == PM_RUN);
   ack_clear_c: cover property (
      flag_reg && cpu_ev.irq_ack_wake ##1 !flag_reg);
   set_beats_clear_c: cover property (
      expire && cpu_ev.irq_ack_wake);
   stop_wins_c: cover property (
      pm_reg == PM_RUN && wr_pmc && hwdata[`PMC_STOP_BIT] && hwdata[`PMC_IDLE_BIT]);

endmodule

`default_nettype wire

// File: testbench/cpu_core_model.sv
`timescale 1ns/1ns
`default_nettype none

module cpu_core_model
   import wake_timer_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // from the block
   input wire logic wake_irq,
   input wire logic cpu_hold,
   // scenario controls
   input wire logic ack_en,
   input wire logic g0,
   input wire logic g2,
   input wire logic rst_in,
   input wire logic irq_en,
   input wire logic wdt,
   // to the block
   output var cpu_events_t cpu_ev
);
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cpu_ev <= '0;
      end else begin
         cpu_ev.ext_irq_group0 <= g0;
         cpu_ev.ext_irq_group2 <= g2;
         cpu_ev.ext_reset_in <= rst_in;
         cpu_ev.wdt_enable <= wdt;
         // a halted core takes no vector, so the acknowledge waits for wake-up
         cpu_ev.irq_ack_wake <= wake_irq & ack_en & ~cpu_hold & ~cpu_ev.irq_ack_wake;
         // the wake flag counts as an enabled source whenever ack_en is set, before the core accepts it
         cpu_ev.any_irq_enabled <= irq_en | (wake_irq & ack_en);
      end
   end
endmodule

`default_nettype wire

// File: testbench/tb_wake_timer_power_modes.sv
`timescale 1ns/1ns
`default_nettype none
`include "wake_timer_params.svh"

module tb_wake_timer_power_modes;
   import wake_timer_pkg::*;
   localparam int BT = 4;
   logic ref_clk = 0, nrst = 0, hsel = 0, hwrite = 0;
   logic hresp, hreadyout, wake_irq, hf_clk_en, cpu_hold, lf_osc_en, seen;
   logic ack_en = 0, g0 = 0, g2 = 0, rst_in = 0, irq_en = 0, wdt = 0;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   cpu_events_t cpu_ev;
   int fail_count = 0, num_checks = 0, cyc = 0;

   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;

   wake_timer_power_modes #(.BASE_TICKS(BT)) DUT (.ref_clk(ref_clk), .nrst(nrst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .cpu_ev(cpu_ev), .wake_irq(wake_irq), .hf_clk_en(hf_clk_en),
      .cpu_hold(cpu_hold), .lf_osc_en(lf_osc_en));

   cpu_core_model partner (.ref_clk(ref_clk), .nrst(nrst), .wake_irq(wake_irq),
      .cpu_hold(cpu_hold), .ack_en(ack_en), .g0(g0), .g2(g2), .rst_in(rst_in),
      .irq_en(irq_en), .wdt(wdt), .cpu_ev(cpu_ev));

   task automatic print_verdict;
      if (fail_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask

   // entered just after a rising edge; the address phase is held until taken
   task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {22'h0, i, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= `HSIZE_WORD;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
      chk("hresp", {31'h0, `HRESP_OKAY}, {31'h0, hresp});
   endtask

   task automatic wait_rise(input int lim);
      for (int n = 0; n < lim && wake_irq !== 1'b1; n++) @(posedge ref_clk);
      seen = (wake_irq === 1'b1);
   endtask

   task automatic t_reset;
      bus(0, `WTC_INDEX, 0);
      chk("timer ctl reset", {24'h0, `WTC_RESET}, rd);
      bus(0, `PMC_INDEX, 0);
      chk("mode reg read", 0, rd);
      bus(0, 8'h10, 0);
      chk("unmapped read", 0, rd);
      bus(1, `WTC_INDEX, 32'h7f);
      bus(0, `WTC_INDEX, 0);
      chk("flag write one", 32'h0f, rd);
      bus(1, `WTC_INDEX, 0);
   endtask

   task automatic t_period(input logic [3:0] s);
      int t0;
      int p;
      p = (BT << s) * 100000 / 128;
      bus(1, `WTC_INDEX, {24'h0, 4'h8, s});
      repeat (2) @(posedge ref_clk);
      chk("osc on", 1, lf_osc_en);
      wait_rise(3 * p);
      chk("first flag", 1, seen);
      t0 = cyc;
      bus(1, `WTC_INDEX, {24'h0, 4'h8, s});
      chk("soft clear", 0, wake_irq);
      wait_rise(2 * p);
      chk("second flag", 1, seen);
      // four slow ticks span exactly 3125 fast cycles, so the period has no drift
      chk("period", 1, (cyc - t0 >= p - 1) && (cyc - t0 <= p + 1));
      bus(1, `WTC_INDEX, 0);
   endtask

   task automatic t_ack;
      ack_en <= 1'b1;
      bus(1, `WTC_INDEX, 32'h80);
      wait_rise(10000);
      chk("ack flag raised", 1, seen);
      repeat (4) @(posedge ref_clk);
      chk("ack clear", 0, wake_irq);
      ack_en <= 1'b0;
      bus(1, `WTC_INDEX, 0);
   endtask

   task automatic t_quiet;
      bus(1, `WTC_INDEX, 32'h89);
      wait_rise(8000);
      chk("reserved code", 0, seen);
      bus(1, `WTC_INDEX, 32'h00);
      wait_rise(8000);
      chk("timer stopped", 0, seen);
      chk("osc off", 0, lf_osc_en);
   endtask

   task automatic t_stop;
      for (int k = 0; k < 4; k++) begin
         wdt <= (k == 0);
         bus(1, `WTC_INDEX, (k == 3) ? 32'h80 : 32'h0);
         // both mode bits at once on the third pass: stop must win
         bus(1, `PMC_INDEX, (k == 2) ? 32'h3 : 32'h2);
         repeat (8) @(posedge ref_clk);
         chk("hf clk off", 0, hf_clk_en);
         chk("held", 1, cpu_hold);
         chk("osc in stop", (k == 0 || k == 3), lf_osc_en);
         bus(0, `STAT_INDEX, 0);
         chk("stop status", {28'h0, (k == 3), (k == 0 || k == 3), 2'h2}, rd);
         if (k < 3) begin
            irq_en <= 1'b1;
            repeat (4) @(posedge ref_clk);
            chk("still stopped", 0, hf_clk_en);
            irq_en <= 1'b0;
         end
         g0 <= (k == 0);
         g2 <= (k == 1);
         rst_in <= (k == 2);
         for (int n = 0; n < 8000 && hf_clk_en !== 1'b1; n++) @(posedge ref_clk);
         chk("stop wake", 1, hf_clk_en);
         chk("released", 0, cpu_hold);
         g0 <= 1'b0;
         g2 <= 1'b0;
         rst_in <= 1'b0;
         wdt <= 1'b0;
         @(posedge ref_clk);
         bus(1, `WTC_INDEX, 0);
      end
   endtask

   task automatic t_idle;
      bus(1, `WTC_INDEX, 32'h05);
      bus(1, `PMC_INDEX, 32'h1);
      repeat (8) @(posedge ref_clk);
      chk("idle hold", 1, cpu_hold);
      chk("idle clk", 1, hf_clk_en);
      bus(1, `PMC_INDEX, 32'h2);
      @(posedge ref_clk);
      chk("mode write ignored", 1, hf_clk_en);
      bus(0, `WTC_INDEX, 0);
      chk("state kept", 32'h05, rd);
      bus(0, `STAT_INDEX, 0);
      chk("idle status", 32'h1, rd);
      irq_en <= 1'b1;
      for (int n = 0; n < 8 && cpu_hold !== 1'b0; n++) @(posedge ref_clk);
      chk("idle wake", 0, cpu_hold);
      irq_en <= 1'b0;
      bus(1, `WTC_INDEX, 0);
   endtask

   initial begin
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      t_reset;
      t_period(4'h0);
      t_period(4'h1);
      t_ack;
      t_quiet;
      t_stop;
      t_idle;
      print_verdict;
   end

   initial begin
      repeat (100000) @(posedge ref_clk);
      fail_count++;
      print_verdict;
   end
endmodule

`default_nettype wire
